// >>> include/pps_pkg.sv
// Functional notes
// - five delays, 1 to 1023 ms, 1 ms steps
// - power-on needs settings and stable detectors
// - power-off on instability or software command
// - power-off runs through, on refused until delay_five
// - watch hsync, vsync, pixel clock; self power-down
// - up needs syncs, clock, pll lock, activate
// - three equal per-frame hsync counts permit power-up
// - vsync gone 2 frames, hsync 32us blocks
// - enabled panel drops on count mismatch or loss
// - pll, sync, clock detectors defeatable separately
// - defeated detectors count as satisfied
// - settings retained through every power-down
package pps_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_CYC = MS_TIME_NS * 1000 / CLK_PERIOD_PS;
    localparam int HS_MISS_NS = 32000;
    localparam int HS_MISS_CYC = HS_MISS_NS * 1000 / CLK_PERIOD_PS;
    localparam int CLK_MISS_NS = 1000;
    localparam int CLK_MISS_CYC = CLK_MISS_NS * 1000 / CLK_PERIOD_PS;
    localparam int DLY_W = 10;
    localparam int LINE_W = 12;
    localparam int TICK_W = 18;
    localparam int HS_W = 13;
    localparam int CK_W = 8;
    localparam int HIST_DEPTH = 3;
    localparam int VS_MISS_FRAMES = 2;
    localparam logic [DLY_W-1:0] DLY_RST = 10'h001;

    typedef enum logic [6:0] {
        PPS_OFF = 7'h01,
        PPS_PWR = 7'h02,
        PPS_DATA = 7'h04,
        PPS_ON = 7'h08,
        PPS_BLOFF = 7'h10,
        PPS_DOFF = 7'h20,
        PPS_HOLD = 7'h40
    } pps_state_e;
endpackage

// >>> design/pps_frame_hist.sv
`timescale 1ns/1ps
module pps_frame_hist import pps_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // frame end counts
    input wire logic clear,
    input wire logic push,
    input wire logic [LINE_W-1:0] cnt,
    // result
    output logic match,
    output logic filled
);
    logic [LINE_W-1:0] mem_reg [HIST_DEPTH];
    logic [1:0] fill_reg;
    logic match_reg;
    wire full = (fill_reg == 2'(HIST_DEPTH));
    wire same = (mem_reg[0] == mem_reg[1]) && (mem_reg[1] == mem_reg[2]);

    // shift register of the last three frame end counts
    genvar i;
    generate
        for (i = 0; i < HIST_DEPTH; i++) begin : g_ent
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    mem_reg[i] <= '0;
                end else if (push) begin
                    mem_reg[i] <= (i == 0) ? cnt : mem_reg[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_n || clear) begin
            fill_reg <= 2'h0;
            match_reg <= 1'b0;
        end else begin
            if (push && !full)
                fill_reg <= fill_reg + 2'h1;
            match_reg <= full && same;
        end
    end

    assign match = match_reg;
    assign filled = full;

    property p_match_needs_full;
        @(posedge sys_clk) disable iff (!rst_n)
        match_reg |-> $past(full) && $past(mem_reg[0]) == $past(mem_reg[2]);
    endproperty
    a_match_needs_full: assert property (p_match_needs_full)
        else $error("count match without three equal frames");
endmodule // pps_frame_hist

// >>> design/pps_seq.sv
`timescale 1ns/1ps
module pps_seq import pps_pkg::*; #(
    parameter int MS_CYCLES = MS_CYC,
    parameter int HS_CYCLES = HS_MISS_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // software settings
    input wire logic cfg_write,
    input wire logic [DLY_W-1:0] delay_one,
    input wire logic [DLY_W-1:0] delay_two,
    input wire logic [DLY_W-1:0] delay_three,
    input wire logic [DLY_W-1:0] delay_four,
    input wire logic [DLY_W-1:0] delay_five,
    input wire logic defeat_pll,
    input wire logic defeat_sync,
    input wire logic defeat_clk,
    input wire logic settings_valid,
    // software commands, one-cycle pulses
    input wire logic activate_output_command,
    input wire logic power_off_command,
    // monitored pins
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic input_pixel_clock,
    input wire logic pll_lock_in,
    // panel enables
    output logic panel_power_enable,
    output logic panel_data_enable,
    output logic backlight_enable,
    // status
    output logic seq_busy,
    output logic timing_stable
);
    logic [DLY_W-1:0] dly_reg [5];
    logic act_reg;
    logic hs_s1, hs_s2, hs_s3, vs_s1, vs_s2, vs_s3;
    logic pc_s1, pc_s2, pc_s3, pl_s1, pl_s2;
    logic [HS_W-1:0] hs_cnt_reg;
    logic [CK_W-1:0] ck_cnt_reg;
    logic [LINE_W-1:0] line_reg, last_reg;
    logic [TICK_W-1:0] tick_reg;
    logic [DLY_W-1:0] ms_reg;
    pps_state_e st_reg, st_next;
    logic pwr_reg, data_reg, bkl_reg;
    logic hist_match;

    // settings kept until rewritten; power-down never clears them
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int k = 0; k < 5; k++)
                dly_reg[k] <= DLY_RST;
        end else if (cfg_write) begin
            dly_reg[0] <= delay_one;
            dly_reg[1] <= delay_two;
            dly_reg[2] <= delay_three;
            dly_reg[3] <= delay_four;
            dly_reg[4] <= delay_five;
        end
    end

    // output activation latch; an off command wins over activate
    always_ff @(posedge sys_clk) begin
        if (!rst_n || power_off_command)
            act_reg <= 1'b0;
        else if (activate_output_command)
            act_reg <= 1'b1;
    end

    // pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {hs_s1, hs_s2, hs_s3} <= 3'h0;
            {vs_s1, vs_s2, vs_s3} <= 3'h0;
            {pc_s1, pc_s2, pc_s3} <= 3'h0;
            {pl_s1, pl_s2} <= 2'h0;
        end else begin
            {hs_s1, hs_s2, hs_s3} <= {hsync_in, hs_s1, hs_s2};
            {vs_s1, vs_s2, vs_s3} <= {vsync_in, vs_s1, vs_s2};
            {pc_s1, pc_s2, pc_s3} <= {input_pixel_clock, pc_s1, pc_s2};
            {pl_s1, pl_s2} <= {pll_lock_in, pl_s1};
        end
    end

    wire hs_rise = hs_s2 && !hs_s3;
    wire vs_rise = vs_s2 && !vs_s3;
    wire pc_edge = pc_s2 ^ pc_s3;
    wire hs_miss = (hs_cnt_reg == HS_W'(HS_CYCLES));
    wire ck_miss = (ck_cnt_reg == CK_W'(CLK_MISS_CYC));
    wire [LINE_W:0] vs_lim = (LINE_W+1)'(VS_MISS_FRAMES) * {1'b0, last_reg};
    wire vs_miss = ({1'b0, line_reg} > vs_lim);

    // absence timers run on the reference clock
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hs_cnt_reg <= '0;
            ck_cnt_reg <= '0;
        end else begin
            if (hs_rise)
                hs_cnt_reg <= '0;
            else if (!hs_miss)
                hs_cnt_reg <= hs_cnt_reg + HS_W'(1);
            if (pc_edge)
                ck_cnt_reg <= '0;
            else if (!ck_miss)
                ck_cnt_reg <= ck_cnt_reg + CK_W'(1);
        end
    end

    // hsync pulses per frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            line_reg <= '0;
            last_reg <= '0;
        end else if (vs_rise) begin
            line_reg <= '0;
            last_reg <= line_reg;
        end else if (hs_rise && line_reg != '1) begin
            line_reg <= line_reg + LINE_W'(1);
        end
    end

    pps_frame_hist u_hist (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clear(hs_miss),
        .push(vs_rise),
        .cnt(line_reg),
        .match(hist_match),
        .filled()
    );

    wire sync_raw = hist_match && !hs_miss && !vs_miss;
    wire sync_ok = defeat_sync || sync_raw;
    wire pll_ok = defeat_pll || pl_s2;
    wire clk_ok = defeat_clk || !ck_miss;
    wire go_ok = settings_valid && act_reg && sync_ok && pll_ok &&
                 clk_ok;

    // millisecond timebase restarted on every state change
    wire ent = (st_next != st_reg);
    wire ms_tick = (tick_reg == TICK_W'(MS_CYCLES - 1));
    wire [DLY_W-1:0] dly_raw = st_reg[1] ? dly_reg[0] :
                               st_reg[2] ? dly_reg[1] :
                               st_reg[4] ? dly_reg[2] :
                               st_reg[5] ? dly_reg[3] : dly_reg[4];
    wire [DLY_W-1:0] dly_sel = (dly_raw == '0) ? DLY_W'(1) : dly_raw;
    wire done = (ms_reg >= dly_sel);

    always_ff @(posedge sys_clk) begin
        if (!rst_n || ent) begin
            tick_reg <= '0;
            ms_reg <= '0;
        end else if (ms_tick) begin
            tick_reg <= '0;
            if (ms_reg != '1)
                ms_reg <= ms_reg + DLY_W'(1);
        end else begin
            tick_reg <= tick_reg + TICK_W'(1);
        end
    end

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            PPS_OFF:
                if (go_ok)
                    st_next = PPS_PWR;
            PPS_PWR:
                if (!go_ok)
                    st_next = PPS_BLOFF;
                else if (done)
                    st_next = PPS_DATA;
            PPS_DATA:
                if (!go_ok)
                    st_next = PPS_BLOFF;
                else if (done)
                    st_next = PPS_ON;
            PPS_ON:
                if (!go_ok)
                    st_next = PPS_BLOFF;
            PPS_BLOFF:
                if (done)
                    st_next = PPS_DOFF;
            PPS_DOFF:
                if (done)
                    st_next = PPS_HOLD;
            PPS_HOLD:
                if (done)
                    st_next = PPS_OFF;
            default:
                st_next = PPS_OFF;
        endcase
    end

    wire pwr_next = !(st_next == PPS_OFF || st_next == PPS_HOLD);
    wire data_next = (st_next == PPS_DATA) || (st_next == PPS_ON) ||
                     (st_next == PPS_BLOFF && data_reg);
    wire bkl_next = (st_next == PPS_ON);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= PPS_OFF;
            pwr_reg <= 1'b0;
            data_reg <= 1'b0;
            bkl_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            pwr_reg <= pwr_next;
            data_reg <= data_next;
            bkl_reg <= bkl_next;
        end
    end

    assign panel_power_enable = pwr_reg;
    assign panel_data_enable = data_reg;
    assign backlight_enable = bkl_reg;
    assign seq_busy = (st_reg != PPS_OFF) && (st_reg != PPS_ON);
    assign timing_stable = sync_ok && pll_ok && clk_ok;

    property p_bkl_order;
        @(posedge sys_clk) disable iff (!rst_n)
        backlight_enable |-> panel_data_enable && panel_power_enable;
    endproperty
    a_bkl_order: assert property (p_bkl_order)
        else $error("backlight on without data and power");

    property p_data_needs_pwr;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(panel_data_enable) |-> $past(panel_power_enable, 2) &&
            st_reg == PPS_DATA;
    endproperty
    a_data_needs_pwr: assert property (p_data_needs_pwr)
        else $error("data started before panel power settled");

    property p_on_cause;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(panel_power_enable) |-> $past(go_ok) && $past(st_reg == PPS_OFF);
    endproperty
    a_on_cause: assert property (p_on_cause)
        else $error("power-up without all conditions met");

    property p_drop_on_loss;
        @(posedge sys_clk) disable iff (!rst_n)
        st_reg == PPS_ON && !go_ok |=>
            st_reg == PPS_BLOFF && !backlight_enable;
    endproperty
    a_drop_on_loss: assert property (p_drop_on_loss)
        else $error("lost condition did not start power-off");

    property p_clk_loss;
        @(posedge sys_clk) disable iff (!rst_n)
        st_reg == PPS_ON && ck_miss && !defeat_clk |=> !backlight_enable;
    endproperty
    a_clk_loss: assert property (p_clk_loss)
        else $error("missing pixel clock did not drop backlight");

    property p_off_runs_through;
        @(posedge sys_clk) disable iff (!rst_n)
        st_reg == PPS_HOLD && !done |=>
            st_reg == PPS_HOLD && !panel_power_enable;
    endproperty
    a_off_runs_through: assert property (p_off_runs_through)
        else $error("power-on allowed before delay_five elapsed");

    property p_hs_block;
        @(posedge sys_clk) disable iff (!rst_n)
        hs_miss && !defeat_sync |-> !timing_stable ##1 !hist_match;
    endproperty
    a_hs_block: assert property (p_hs_block)
        else $error("hsync absence did not block power-up");

    property p_defeat_all;
        @(posedge sys_clk) disable iff (!rst_n)
        st_reg == PPS_OFF && settings_valid && act_reg && defeat_pll &&
        defeat_sync && defeat_clk |=> st_reg == PPS_PWR && panel_power_enable;
    endproperty
    a_defeat_all: assert property (p_defeat_all)
        else $error("defeated detectors still held off power-up");

    property p_tick_period;
        @(posedge sys_clk) disable iff (!rst_n)
        ms_tick && !ent |=> tick_reg == '0 && ms_reg != '0;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("millisecond tick did not restart");

    property p_cfg_kept;
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_write |=> dly_reg[4] == $past(delay_five) &&
            dly_reg[0] == $past(delay_one);
    endproperty
    a_cfg_kept: assert property (p_cfg_kept)
        else $error("delay settings not captured");
endmodule // pps_seq

// >>> tb/pps_panel_model.sv
`timescale 1ns/1ps
module pps_panel_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // enables seen by the panel
    input wire logic power_en,
    input wire logic data_en,
    input wire logic light_en,
    // count of order faults
    output int faults
);
    // data needs the supply, the backlight needs data
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            faults <= 0;
        end else if ((data_en && !power_en) || (light_en && !data_en)) begin
            faults <= faults + 1;
        end
    end
endmodule // pps_panel_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import pps_pkg::*;;
    localparam int MS = 4;
    localparam int HS = 60;
    logic sys_clk, rst_n, cfg_write, settings_valid, act, poff, pix;
    logic defeat_pll, defeat_sync, defeat_clk, hsync_in, vsync_in, pll;
    logic [DLY_W-1:0] d1, d2, d3, d4, d5;
    logic pwr, dat, bkl, busy, stable, hs_on, vs_on, ck_on, odd;
    int n_errors, num_checks, faults, cyc, line, flen;
    wire [2:0] en = {bkl, dat, pwr};

    pps_seq #(.MS_CYCLES(MS), .HS_CYCLES(HS)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cfg_write(cfg_write),
        .delay_one(d1), .delay_two(d2), .delay_three(d3),
        .delay_four(d4), .delay_five(d5), .defeat_pll(defeat_pll),
        .defeat_sync(defeat_sync), .defeat_clk(defeat_clk),
        .settings_valid(settings_valid), .activate_output_command(act),
        .power_off_command(poff), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .input_pixel_clock(pix),
        .pll_lock_in(pll), .panel_power_enable(pwr),
        .panel_data_enable(dat), .backlight_enable(bkl),
        .seq_busy(busy), .timing_stable(stable)
    );
    pps_panel_model u_panel (
        .sys_clk(sys_clk), .rst_n(rst_n), .power_en(pwr),
        .data_en(dat), .light_en(bkl), .faults(faults)
    );

    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // video source: 10-cycle lines, 6-line frames, 6/7 when odd is set
    always @(negedge sys_clk) begin
        if (!rst_n) begin
            {pix, hsync_in, vsync_in} <= 3'h0;
            {cyc, line, flen} <= {32'd0, 32'd0, 32'd6};
        end else begin
            if (ck_on) begin
                pix <= ~pix;
            end
            cyc <= (cyc == 9) ? 0 : cyc + 1;
            hsync_in <= hs_on && cyc == 0;
            vsync_in <= vs_on && line == 0 && cyc < 3;
            if (cyc == 9) begin
                line <= (line >= flen - 1) ? 0 : line + 1;
                if (line >= flen - 1 && odd) begin
                    flen <= 13 - flen;
                end
            end
        end
    end

    task chk(string what, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task tick(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    // enable idx must hold !v until n-1 edges on, then show v at edge n
    task edge_at(int idx, int n, logic v);
        tick(n - 1);
        chk($sformatf("enable %0d early", idx), !v, en[idx]);
        tick(1);
        chk($sformatf("enable %0d", idx), v, en[idx]);
    endtask
    task wait_low(int idx, int lim);
        for (int k = 0; k < lim && en[idx] !== 1'b0; k++) tick(1);
        chk("protect shutdown", 0, en[idx]);
    endtask
    task settle();
        for (int k = 0; k < 2000 && (busy !== 1'b0 || pwr !== 1'b0); k++)
            tick(1);
        chk("sequence idle", 0, busy);
    endtask
    task close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // each state lasts its delay in ms ticks plus the edge that ends it
    task t_default();
        chk("power at reset", 0, pwr);
        pulse(cfg_write);
        pulse(act);
        edge_at(0, 1, 1);
        edge_at(1, MS + 1, 1);
        edge_at(2, MS + 1, 1);
        pulse(poff);
        edge_at(2, 1, 0);
        edge_at(1, MS + 1, 0);
        edge_at(0, MS + 1, 0);
        settle();
    endtask
    task t_program();
        {d1, d2, d3, d4, d5} = {10'h002, 10'h003, 10'h001, 10'h002, 10'h003};
        pulse(cfg_write);
        pulse(act);
        edge_at(0, 1, 1);
        edge_at(1, 2 * MS + 1, 1);
        edge_at(2, 3 * MS + 1, 1);
        tick(5);
        pulse(poff);
        edge_at(2, 1, 0);
        edge_at(1, MS + 1, 0);
        edge_at(0, 2 * MS + 1, 0);
        chk("hold busy", 1, busy);
        pulse(act);
        edge_at(0, 3 * MS + 1, 1);
        edge_at(1, 2 * MS + 1, 1);
        pulse(poff);
        settle();
    endtask
    task t_gate();
        settings_valid = 0;
        pulse(act);
        tick(20);
        chk("power without settings", 0, pwr);
        pulse(poff);
        settings_valid = 1;
        tick(20);
        chk("power after command off", 0, pwr);
        pulse(act);
        edge_at(0, 1, 1);
        pulse(poff);
        tick(2);
        chk("data on early abort", 0, dat);
        settle();
    endtask
    task t_sync();
        {defeat_pll, defeat_sync, defeat_clk} = 3'h0;
        tick(400);
        chk("sync stable", 1, stable);
        pulse(act);
        tick(30);
        chk("backlight up", 1, bkl);
        hs_on = 0;
        wait_low(2, HS + 40);
        chk("hsync gone", 0, stable);
        settle();
        pulse(poff);
        hs_on = 1;
        tick(400);
        pulse(act);
        tick(30);
        chk("backlight again", 1, bkl);
        vs_on = 0;
        wait_low(2, 300);
        settle();
        pulse(poff);
        vs_on = 1;
        odd = 1;
        tick(400);
        chk("unequal frames", 0, stable);
        odd = 0;
        tick(400);
        chk("equal frames", 1, stable);
    endtask
    task t_clk();
        pulse(act);
        tick(30);
        chk("backlight up", 1, bkl);
        ck_on = 0;
        wait_low(2, 300);
        chk("clock gone", 0, stable);
        settle();
        pulse(poff);
        defeat_clk = 1;
        tick(5);
        chk("clock defeated", 1, stable);
        pll = 0;
        tick(5);
        chk("pll unlocked", 0, stable);
        defeat_pll = 1;
        {hs_on, vs_on, defeat_sync} = 3'h1;
        tick(5);
        chk("all defeated", 1, stable);
    endtask

    initial begin
        {rst_n, cfg_write, act, poff, odd} = 5'h00;
        {defeat_pll, defeat_sync, defeat_clk, settings_valid} = 4'hf;
        {pll, hs_on, vs_on, ck_on} = 4'hf;
        {d1, d2, d3, d4, d5} = '0;
        {n_errors, num_checks} = {32'd0, 32'd0};
        tick(3);
        rst_n = 1;
        tick(1);
        t_default();
        t_program();
        t_gate();
        t_sync();
        t_clk();
        chk("panel order", 1, faults == 0);
        close_out();
    end
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule // tb_top
